// ===== verilog/mrxl_pkg.sv
`default_nettype none
// Shared constants for the receive lane deserializer
package mrxl_pkg;
  // APB register byte offsets
  localparam logic [7:0] MRXL_CTRL_OFS   = 8'h00;
  localparam logic [7:0] MRXL_STATUS_OFS = 8'h04;
  localparam logic [7:0] MRXL_WORD_OFS   = 8'h08;
  // Control register fields
  localparam int MRXL_CTRL_HS_EN_BIT   = 0;
  localparam int MRXL_CTRL_TERM_BIT    = 1;
  localparam int MRXL_CTRL_FIFO_BIT    = 2;
  localparam int MRXL_CTRL_CLEAR_BIT   = 3;
  localparam logic [31:0] MRXL_CTRL_RST = 32'h0000_0003;
  // Status register fields
  localparam int MRXL_STAT_EMPTY_BIT   = 0;
  localparam int MRXL_STAT_DLY_LSB     = 8;
  localparam int MRXL_STAT_LEVEL_LSB   = 16;
  // Deserializer geometry: 1 to 8, both serial edges carry a bit
  localparam int MRXL_WORD_W           = 8;
  localparam logic [2:0] MRXL_LAST_BIT = 3'h7;
  // Last serial edge count in a half period of the divided clocks, which is four serial edges long
  localparam logic [2:0] MRXL_HALF_DIV = 3'h3;
  // Input delay counter
  localparam int MRXL_DLY_W            = 6;
  localparam logic [5:0] MRXL_DLY_INIT = 6'h00;
  localparam logic [5:0] MRXL_DLY_MAX  = 6'h3F;
  // APB answer latency in clk_in cycles after the access phase starts
  localparam int MRXL_APB_WAIT         = 1;
endpackage
`default_nettype wire

// ===== verilog/mrxl_lane.sv
`timescale 1ns/1ps
`default_nettype none
module mrxl_lane #(
  parameter int FIFO_DEPTH = 8,      // Words held by the optional queue
  parameter int ADDR_W     = 8       // APB address width
) (
  input  wire logic              clk_in,                    // System clock, 100 MHz
  input  wire logic              reset_n_in,                // Synchronous reset
  // APB slave
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic                   pready_out,
  output logic [31:0]            prdata_out,
  output logic                   pslverr_out,
  // High-speed pads (already differential-resolved)
  input  wire logic              serial_clock_pad_in,       // Clock lane pad level
  input  wire logic              hs_data_pad_in,            // Data lane pad level
  output logic                   hs_buffer_en_out,          // Receiver enable to pad
  output logic                   hs_termination_en_out,     // Termination enable to pad
  // Low-power pads, P and N
  input  wire logic              lp_pos_pad_in,
  input  wire logic              lp_neg_pad_in,
  output logic                   lp_pos_pad_out,
  output logic                   lp_pos_pad_oe_out,
  output logic                   lp_neg_pad_out,
  output logic                   lp_neg_pad_oe_out,
  // Fabric side
  input  wire logic              lp_pos_drive_en_in,
  input  wire logic              lp_pos_drive_val_in,
  input  wire logic              lp_neg_drive_en_in,
  input  wire logic              lp_neg_drive_val_in,
  output logic                   lp_pos_sense_out,
  output logic                   lp_neg_sense_out,
  input  wire logic              delay_step_en_in,
  input  wire logic              delay_step_dir_in,
  input  wire logic              delay_count_clear_in,
  input  wire logic              lane_clear_in,             // Lane reset request
  input  wire logic              queue_read_en_in,          // Pop one word
  output logic                   queue_empty_out,
  output logic [7:0]             hs_parallel_word_out,
  output logic                   hs_word_valid_out,         // One cycle per new word
  output logic [5:0]             delay_count_out,
  output logic                   lane_serial_clk_feed_out,
  output logic                   lane_parallel_clk_feed_out,
  output logic                   fabric_byte_clock_out,
  output logic                   global_div4_clock_out
);
  import mrxl_pkg::*;

  localparam int PTR_W = $clog2(FIFO_DEPTH);

  // Refuse queue depths the pointer logic cannot wrap on
  if (FIFO_DEPTH < 2 || (1 << PTR_W) != FIFO_DEPTH) begin : g_depth_check
    $error("FIFO_DEPTH must be a power of two, at least 2");
  end

  // Whole state of the lane in one record
  typedef struct packed {
    logic [2:0]                  sclk_sync;   // Serial clock synchroniser
    logic [2:0]                  data_sync;   // Data pad synchroniser
    logic [2:0]                  lpp_sync;    // LP P synchroniser
    logic [2:0]                  lpn_sync;    // LP N synchroniser
    logic                        sclk_flt;    // Filtered serial clock level
    logic [2:0]                  edge_cnt;    // Serial edges in half period
    logic [7:0]                  shift;       // Incoming bits, first in LSB
    logic [2:0]                  bit_cnt;     // Bits gathered so far
    logic                        par_clk;     // Divided clock level
    logic [7:0]                  word;        // Parallel word output
    logic                        word_vld;    // Word strobe
    logic [FIFO_DEPTH-1:0][7:0]  mem;         // Queue storage
    logic [PTR_W:0]              wptr;        // Queue write pointer
    logic [PTR_W:0]              rptr;        // Queue read pointer
    logic                        empty;       // Registered empty flag
    logic [5:0]                  dly;         // Input delay counter
    logic                        hs_en;       // Receiver enable
    logic                        term_en;     // Termination enable
    logic                        fifo_en;     // Queue in use
    logic                        lpp_in;      // Sensed LP P
    logic                        lpn_in;      // Sensed LP N
    logic                        lpp_oe;
    logic                        lpp_o;
    logic                        lpn_oe;
    logic                        lpn_o;
    logic                        pready;
    logic [31:0]                 prdata;
    logic                        pslverr;
  } mrxl_state_s;

  mrxl_state_s st_q;  // Registered state
  mrxl_state_s st_d;  // Next state

  // Fill level of the queue from its pointers
  function automatic logic [PTR_W:0] mrxl_level(input logic [PTR_W:0] w,
                                                input logic [PTR_W:0] r);
    mrxl_level = w - r;
  endfunction

  // Next-state logic
  always_comb begin
    logic         sclk_edge;   // Filtered serial clock changed
    logic         par_rise;    // Divided clock about to rise
    logic         word_done;   // Eighth bit arrives now
    logic [7:0]   new_word;    // Word completed this cycle
    logic         push;
    logic         pop;
    logic         clear;
    logic         acc;
    logic [7:0]   ofs;
    sclk_edge = 1'b0;
    par_rise  = 1'b0;
    word_done = 1'b0;
    new_word  = 8'h00;
    push      = 1'b0;
    pop       = 1'b0;
    clear     = lane_clear_in;  // Lane clear request from fabric or software
    acc       = 1'b0;
    ofs       = 8'h00;
    st_d      = st_q;

    // Three-stage synchronisers; only stage 2 and 3 are looked at
    st_d.sclk_sync = {st_q.sclk_sync[1:0], serial_clock_pad_in};
    st_d.data_sync = {st_q.data_sync[1:0], hs_data_pad_in};
    st_d.lpp_sync  = {st_q.lpp_sync[1:0], lp_pos_pad_in};
    st_d.lpn_sync  = {st_q.lpn_sync[1:0], lp_neg_pad_in};

    // Serial clock change is accepted once stages 2 and 3 agree
    if (st_q.sclk_sync[1] == st_q.sclk_sync[2] && st_q.sclk_sync[2] != st_q.sclk_flt) begin
      sclk_edge     = 1'b1;
      st_d.sclk_flt = st_q.sclk_sync[2];
    end

    if (sclk_edge) begin
      st_d.edge_cnt = st_q.edge_cnt + 3'h1;
      if (st_q.edge_cnt == MRXL_HALF_DIV) begin
        st_d.edge_cnt = 3'h0;
        st_d.par_clk  = ~st_q.par_clk;
        par_rise      = ~st_q.par_clk;
      end
    end

    // DDR capture, eight bits per word
    if (sclk_edge && st_q.hs_en) begin
      new_word     = {st_q.data_sync[2], st_q.shift[7:1]};
      st_d.shift   = new_word;
      st_d.bit_cnt = st_q.bit_cnt + 3'h1;
      word_done    = (st_q.bit_cnt == MRXL_LAST_BIT);
    end

    // APB access phase, answered one cycle later
    acc          = psel_in && penable_in && !st_q.pready;
    ofs          = 8'(paddr_in);
    st_d.pready  = acc;
    st_d.pslverr = 1'b0;
    if (acc) begin
      st_d.prdata = 32'h0000_0000;
      unique case (ofs)
        MRXL_CTRL_OFS: begin
          st_d.prdata = {28'h0000000, 1'b0, st_q.fifo_en, st_q.term_en, st_q.hs_en};
          if (pwrite_in) begin
            st_d.hs_en   = pwdata_in[MRXL_CTRL_HS_EN_BIT];
            st_d.term_en = pwdata_in[MRXL_CTRL_TERM_BIT];
            st_d.fifo_en = pwdata_in[MRXL_CTRL_FIFO_BIT];
            clear        = clear | pwdata_in[MRXL_CTRL_CLEAR_BIT];
          end
        end
        MRXL_STATUS_OFS: begin
          st_d.prdata[MRXL_STAT_EMPTY_BIT] = st_q.empty;
          st_d.prdata[MRXL_STAT_DLY_LSB +: MRXL_DLY_W] = st_q.dly;
          st_d.prdata[MRXL_STAT_LEVEL_LSB +: PTR_W+1] = mrxl_level(st_q.wptr, st_q.rptr);
          st_d.pslverr = pwrite_in;
        end
        MRXL_WORD_OFS: begin
          st_d.prdata  = {24'h000000, st_q.word};
          st_d.pslverr = pwrite_in;
        end
        default: begin
          // Unmapped address: error answer, reads zero
          st_d.pslverr = 1'b1;
        end
      endcase
    end

    // publish word when queue is bypassed
    st_d.word_vld = 1'b0;
    if (word_done && !st_q.fifo_en) begin
      st_d.word     = new_word;
      st_d.word_vld = 1'b1;
    end

    pop  = st_q.fifo_en && queue_read_en_in && !st_q.empty;
    push = st_q.fifo_en && word_done &&
           (mrxl_level(st_q.wptr, st_q.rptr) != (PTR_W+1)'(FIFO_DEPTH));
    if (pop) begin
      st_d.word     = st_q.mem[st_q.rptr[PTR_W-1:0]];
      st_d.word_vld = 1'b1;
      st_d.rptr     = st_q.rptr + (PTR_W+1)'(1);
    end
    if (push) begin
      st_d.mem[st_q.wptr[PTR_W-1:0]] = new_word;
      st_d.wptr                      = st_q.wptr + (PTR_W+1)'(1);
    end

    if (clear) begin
      st_d.wptr     = '0;
      st_d.rptr     = '0;
      st_d.shift    = 8'h00;
      st_d.bit_cnt  = 3'h0;
      st_d.word_vld = 1'b0;
    end

    // empty flag from the next pointers
    st_d.empty = (st_d.wptr == st_d.rptr);

    // delay step on parallel clock rise
    if (par_rise && delay_step_en_in) begin
      if (delay_step_dir_in && st_q.dly != MRXL_DLY_MAX) begin
        st_d.dly = st_q.dly + 6'h01;
      end else if (!delay_step_dir_in && st_q.dly != MRXL_DLY_INIT) begin
        st_d.dly = st_q.dly - 6'h01;
      end
    end
    if (par_rise && delay_count_clear_in) begin
      st_d.dly = MRXL_DLY_INIT;
    end

    // sensed LP levels, stable once stages agree
    if (st_q.lpp_sync[1] == st_q.lpp_sync[2]) begin
      st_d.lpp_in = st_q.lpp_sync[2];
    end
    if (st_q.lpn_sync[1] == st_q.lpn_sync[2]) begin
      st_d.lpn_in = st_q.lpn_sync[2];
    end

    st_d.lpp_oe = lp_pos_drive_en_in;
    st_d.lpp_o  = lp_pos_drive_val_in;
    st_d.lpn_oe = lp_neg_drive_en_in;
    st_d.lpn_o  = lp_neg_drive_val_in;
  end

  // State register with synchronous reset
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      st_q         <= '0;
      st_q.empty   <= 1'b1;
      st_q.dly     <= MRXL_DLY_INIT;
      st_q.hs_en   <= MRXL_CTRL_RST[MRXL_CTRL_HS_EN_BIT];
      st_q.term_en <= MRXL_CTRL_RST[MRXL_CTRL_TERM_BIT];
      st_q.fifo_en <= MRXL_CTRL_RST[MRXL_CTRL_FIFO_BIT];
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from state; one clock lane feeds this lane
  assign pready_out                 = st_q.pready;
  assign prdata_out                 = st_q.prdata;
  assign pslverr_out                = st_q.pslverr;
  assign hs_buffer_en_out           = st_q.hs_en;
  assign hs_termination_en_out      = st_q.term_en;
  assign lp_pos_pad_out             = st_q.lpp_o;
  assign lp_pos_pad_oe_out          = st_q.lpp_oe;
  assign lp_neg_pad_out             = st_q.lpn_o;
  assign lp_neg_pad_oe_out          = st_q.lpn_oe;
  assign lp_pos_sense_out           = st_q.lpp_in;
  assign lp_neg_sense_out           = st_q.lpn_in;
  assign queue_empty_out            = st_q.empty;
  assign hs_parallel_word_out       = st_q.word;
  assign hs_word_valid_out          = st_q.word_vld;
  assign delay_count_out            = st_q.dly;
  assign lane_serial_clk_feed_out   = st_q.sclk_flt;
  assign lane_parallel_clk_feed_out = st_q.par_clk;
  assign fabric_byte_clock_out      = st_q.par_clk;
  assign global_div4_clock_out      = st_q.par_clk;

  // Checks on lane behaviour
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // Delay step up lands one edge later
  property p_dly_up;
    st_q.edge_cnt == MRXL_HALF_DIV && !st_q.par_clk && st_q.sclk_sync[1] == st_q.sclk_sync[2]
      && st_q.sclk_sync[2] != st_q.sclk_flt && delay_step_en_in && delay_step_dir_in
      && !delay_count_clear_in && st_q.dly != MRXL_DLY_MAX
      |=> st_q.dly == $past(st_q.dly) + 6'h01;
  endproperty
  a_dly_up: assert property (p_dly_up) else $error("delay did not step up");
  // Delay clear on parallel rise restores reset value
  property p_dly_clr;
    st_q.edge_cnt == MRXL_HALF_DIV && !st_q.par_clk && st_q.sclk_sync[1] == st_q.sclk_sync[2]
      && st_q.sclk_sync[2] != st_q.sclk_flt && delay_count_clear_in
      |=> st_q.dly == MRXL_DLY_INIT;
  endproperty
  a_dly_clr: assert property (p_dly_clr) else $error("delay clear ignored");
  // A queue holding words stays non-empty without a pop, clear or write
  property p_empty;
    !queue_empty_out && !queue_read_en_in && !lane_clear_in && !(psel_in && pwrite_in)
      |=> !queue_empty_out;
  endproperty
  a_empty: assert property (p_empty) else $error("empty flag wrong");
  // Clear leaves queue empty
  property p_clear;
    lane_clear_in |=> queue_empty_out && st_q.bit_cnt == 3'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("lane clear incomplete");
  // Divided clock changes only after four serial edges
  property p_div;
    $changed(st_q.par_clk) |-> $past(st_q.edge_cnt) == MRXL_HALF_DIV && $changed(st_q.sclk_flt);
  endproperty
  a_div: assert property (p_div) else $error("divider out of step");
  // Global clock moves only on the fourth accepted serial edge
  property p_div4;
    $changed(global_div4_clock_out) |-> $past(st_q.edge_cnt) == MRXL_HALF_DIV;
  endproperty
  a_div4: assert property (p_div4) else $error("div4 clock mismatch");
  // Receiver disabled means no bit gathered; only a clear may zero the count
  property p_hs_gate;
    !st_q.hs_en ##1 !st_q.hs_en |-> $stable(st_q.bit_cnt) || st_q.bit_cnt == 3'h0;
  endproperty
  a_hs_gate: assert property (p_hs_gate) else $error("bits taken while disabled");
  // Pad drive follows fabric request one cycle later
  property p_lp_drive;
    lp_pos_drive_en_in |=> lp_pos_pad_oe_out && lp_pos_pad_out == $past(lp_pos_drive_val_in);
  endproperty
  a_lp_drive: assert property (p_lp_drive) else $error("LP drive wrong");
  // Pop of a non-empty queue yields a valid word
  property p_pop;
    st_q.fifo_en && queue_read_en_in && !queue_empty_out && !lane_clear_in
      |=> hs_word_valid_out;
  endproperty
  a_pop: assert property (p_pop) else $error("pop gave no word");
  // Termination follows the control register
  property p_term;
    psel_in && penable_in && !pready_out && pwrite_in && paddr_in == ADDR_W'(MRXL_CTRL_OFS)
      |=> hs_termination_en_out == $past(pwdata_in[MRXL_CTRL_TERM_BIT]) ##1 pready_out == 1'b0;
  endproperty
  a_term: assert property (p_term) else $error("termination not set");
endmodule
`default_nettype wire

// ===== dv/mrxl_hs_source.sv
`timescale 1ns/1ps
`default_nettype none
// Far-end transmitter model: drives the clock and data pads of one lane
module mrxl_hs_source #(
  parameter int HOLD = 6  // Cycles between each data change and clock change; a pad level lasts twice this, the lane needs at least 2
) (
  input  wire logic clk_in,
  output logic      serial_clock_pad_out,
  output logic      hs_data_pad_out
);
  // Pads start low before the first frame
  initial begin
    serial_clock_pad_out = 1'b0;
    hs_data_pad_out      = 1'b0;
  end

  // eight bits a word
  // One bit per clock level change, either direction, lowest bit first
  task automatic send_word(input logic [7:0] w);
    for (int i = 0; i < 8; i++) begin
      hs_data_pad_out <= w[i];
      repeat (HOLD) @(posedge clk_in);
      serial_clock_pad_out <= ~serial_clock_pad_out;
      repeat (HOLD) @(posedge clk_in);
    end
    // Clock stands still; data flips so a stale bit is never reused
    hs_data_pad_out <= ~w[7];
  endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mrxl_pkg::*;
  // Design inputs, all low at time zero
  logic        clk_in = 1'b0, reset_n_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0;
  logic        pwrite_in = 1'b0, delay_step_en_in = 1'b0, delay_step_dir_in = 1'b0;
  logic        delay_count_clear_in = 1'b0, lane_clear_in = 1'b0, queue_read_en_in = 1'b0;
  logic        lp_pos_drive_en_in = 1'b0, lp_pos_drive_val_in = 1'b0, far_p = 1'b0;
  logic        lp_neg_drive_en_in = 1'b0, lp_neg_drive_val_in = 1'b0, far_n = 1'b0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0000_0000;
  // Design outputs and pad wires
  logic [31:0] prdata_out;
  logic        pready_out, pslverr_out, hs_buffer_en_out, hs_termination_en_out;
  logic        ser_clk, ser_dat, lp_pos_pad_in, lp_neg_pad_in, queue_empty_out;
  logic        lp_pos_pad_out, lp_pos_pad_oe_out, lp_neg_pad_out, lp_neg_pad_oe_out;
  logic        lp_pos_sense_out, lp_neg_sense_out, hs_word_valid_out;
  logic        ser_feed, par_feed, byte_clk, div4_clk, prev_par;
  logic [7:0]  hs_parallel_word_out;
  logic [5:0]  delay_count_out;
  // Bench state
  logic [7:0]  got_q[$];          // Words seen with the valid pulse
  int          error_cnt, check_count, par_edges, div_err;
  logic [31:0] rd;
  logic        err;
  // Delay table: word, direction, clear and expected count per step
  logic [7:0]  word_v[5] = '{8'hA5, 8'h3C, 8'h0F, 8'h81, 8'hFE};
  logic [5:0]  dly_v[5] = '{6'h01, 6'h02, 6'h01, 6'h00, 6'h00};
  logic [4:0]  dir_v = 5'b01011;
  logic [4:0]  clr_v = 5'b01000;

  // Low-power wires resolve to the lane's level while it drives them
  assign lp_pos_pad_in = lp_pos_pad_oe_out ? lp_pos_pad_out : far_p;
  assign lp_neg_pad_in = lp_neg_pad_oe_out ? lp_neg_pad_out : far_n;

  mrxl_lane uut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .pready_out(pready_out), .prdata_out(prdata_out), .pslverr_out(pslverr_out),
    .serial_clock_pad_in(ser_clk), .hs_data_pad_in(ser_dat),
    .hs_buffer_en_out(hs_buffer_en_out), .hs_termination_en_out(hs_termination_en_out),
    .lp_pos_pad_in(lp_pos_pad_in), .lp_neg_pad_in(lp_neg_pad_in),
    .lp_pos_pad_out(lp_pos_pad_out), .lp_pos_pad_oe_out(lp_pos_pad_oe_out),
    .lp_neg_pad_out(lp_neg_pad_out), .lp_neg_pad_oe_out(lp_neg_pad_oe_out),
    .lp_pos_drive_en_in(lp_pos_drive_en_in), .lp_pos_drive_val_in(lp_pos_drive_val_in),
    .lp_neg_drive_en_in(lp_neg_drive_en_in), .lp_neg_drive_val_in(lp_neg_drive_val_in),
    .lp_pos_sense_out(lp_pos_sense_out), .lp_neg_sense_out(lp_neg_sense_out),
    .delay_step_en_in(delay_step_en_in), .delay_step_dir_in(delay_step_dir_in),
    .delay_count_clear_in(delay_count_clear_in), .lane_clear_in(lane_clear_in),
    .queue_read_en_in(queue_read_en_in), .queue_empty_out(queue_empty_out),
    .hs_parallel_word_out(hs_parallel_word_out), .hs_word_valid_out(hs_word_valid_out),
    .delay_count_out(delay_count_out), .lane_serial_clk_feed_out(ser_feed),
    .lane_parallel_clk_feed_out(par_feed), .fabric_byte_clock_out(byte_clk),
    .global_div4_clock_out(div4_clk)
  );

  mrxl_hs_source src (.clk_in(clk_in), .serial_clock_pad_out(ser_clk), .hs_data_pad_out(ser_dat));

  // 100 MHz clock
  initial begin
    forever #5 clk_in = ~clk_in;
  end

  // Collects delivered words and watches the divided clocks
  always @(posedge clk_in) begin
    if (hs_word_valid_out === 1'b1) got_q.push_back(hs_parallel_word_out);
    if (par_feed !== prev_par) par_edges++;
    if (div4_clk !== par_feed || byte_clk !== par_feed) div_err++;
    prev_par = par_feed;
  end

  // Counts every comparison, reports any mismatch
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic end_of_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= wr;
    paddr_in   <= a;
    pwdata_in  <= wd;
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    if (pready_out !== 1'b1) begin
      chk("apb_timeout", 32'h0, 32'h1);
      end_of_test();
    end
    rd  = prdata_out;
    err = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    // Lets registered control outputs settle before they are checked
    repeat (2) @(posedge clk_in);
  endtask

  // Sends one word and lets the lane finish with it
  task automatic send(input logic [7:0] w);
    src.send_word(w);
    repeat (4) @(posedge clk_in);
  endtask

  // Watchdog cuts a hang short
  initial begin
    repeat (30000) @(posedge clk_in);
    chk("watchdog", 32'h0, 32'h1);
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    chk("rst_empty", queue_empty_out, 1);
    chk("rst_hs_en", hs_buffer_en_out, 1);
    chk("rst_term", hs_termination_en_out, 1);
    chk("rst_delay", delay_count_out, 0);
    apb(1'b0, MRXL_CTRL_OFS, 0);
    chk("ctrl_rst", rd, MRXL_CTRL_RST);
    apb(1'b0, MRXL_STATUS_OFS, 0);
    chk("status_rst", rd, 32'h0000_0001);
    // Bypass words with delay steps; clear beats a step, count floors at zero
    for (int i = 0; i < 5; i++) begin
      delay_step_en_in     <= 1'b1;
      delay_step_dir_in    <= dir_v[i];
      delay_count_clear_in <= clr_v[i];
      got_q.delete();
      par_edges = 0;
      send(word_v[i]);
      chk("par_edges", par_edges, 2);
      chk("word_cnt", got_q.size(), 1);
      chk("word", got_q[0], word_v[i]);
      chk("delay", delay_count_out, dly_v[i]);
    end
    delay_step_en_in     <= 1'b0;
    delay_count_clear_in <= 1'b0;
    chk("div4_same", div_err, 0);
    chk("serial_feed", ser_feed, ser_clk);
    apb(1'b0, MRXL_WORD_OFS, 0);
    chk("word_reg", rd, 32'h0000_00FE);
    // Receiver switched off: no word arrives
    apb(1'b1, MRXL_CTRL_OFS, 32'h0000_0002);
    chk("hs_en_off", hs_buffer_en_out, 0);
    chk("term_on", hs_termination_en_out, 1);
    got_q.delete();
    send(8'h5A);
    chk("no_word", got_q.size(), 0);
    apb(1'b1, MRXL_CTRL_OFS, 32'h0000_0001);
    chk("term_off", hs_termination_en_out, 0);
    // Unmapped and read-only places are refused
    apb(1'b0, 8'h0C, 0);
    chk("unmapped_err", err, 1);
    chk("unmapped_data", rd, 0);
    apb(1'b1, MRXL_STATUS_OFS, 32'hFFFF_FFFF);
    chk("ro_err", err, 1);
    apb(1'b0, MRXL_CTRL_OFS, 0);
    chk("ctrl_kept", rd, 32'h0000_0001);
    chk("ctrl_err", err, 0);
    // Queue filled past its depth; the ninth word is dropped
    apb(1'b1, MRXL_CTRL_OFS, 32'h0000_0005);
    for (int i = 0; i < 9; i++) send(8'(17 * i + 1));
    chk("q_not_empty", queue_empty_out, 0);
    apb(1'b0, MRXL_STATUS_OFS, 0);
    chk("q_level", rd[19:16], 4'h8);
    got_q.delete();
    // back-to-back pops, released as the queue runs dry
    queue_read_en_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    queue_read_en_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk("pop_cnt", got_q.size(), 8);
    for (int i = 0; i < 8; i++) chk("pop_word", got_q[i], 8'(17 * i + 1));
    chk("q_empty", queue_empty_out, 1);
    // Lane clear and control clear both empty the queue
    send(8'h77);
    send(8'h88);
    lane_clear_in <= 1'b1;
    @(posedge clk_in);
    lane_clear_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk("clr_empty", queue_empty_out, 1);
    send(8'h99);
    apb(1'b1, MRXL_CTRL_OFS, 32'h0000_000D);
    chk("ctl_clr_empty", queue_empty_out, 1);
    send(8'h42);
    got_q.delete();
    // one pop for the one queued word
    queue_read_en_in <= 1'b1;
    @(posedge clk_in);
    queue_read_en_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk("after_clr", got_q[0], 8'h42);
    // Low-power sensing and driving, all four far-end level pairs, exactly one side driven at a time
    for (int i = 0; i < 4; i++) begin
      far_p               <= i[0];
      far_n               <= i[1];
      lp_pos_drive_en_in  <= i[1];
      lp_pos_drive_val_in <= ~i[0];
      lp_neg_drive_en_in  <= ~i[1];
      lp_neg_drive_val_in <= i[0];
      repeat (6) @(posedge clk_in);
      chk("lp_pos_drive_en", lp_pos_pad_oe_out, i[1]);
      chk("lp_neg_drive_en", lp_neg_pad_oe_out, !i[1]);
      chk("lp_p_sense", lp_pos_sense_out, i[1] ? !i[0] : i[0]);
      chk("lp_n_sense", lp_neg_sense_out, i[1] ? i[1] : i[0]);
      chk("lp_pos_drive_val", lp_pos_pad_out, !i[0]);
      chk("lp_neg_drive_val", lp_neg_pad_out, i[0]);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
